// ==== common/tester_io_defs.svh ====
// Register offsets, field positions and reset values of the tester control port
`ifndef TESTER_IO_DEFS_SVH
`define TESTER_IO_DEFS_SVH

`define TIO_ADDR_W 8
`define TIO_CTRL_OFS 8'h00
`define TIO_STAT_OFS 8'h04

`define TIO_CTRL_JW_BIT 0
`define TIO_CTRL_JI_BIT 1
`define TIO_CTRL_SIG_LO 2
`define TIO_CTRL_SIG_HI 3
`define TIO_CTRL_CC_BIT 4
`define TIO_CTRL_SINK_BIT 5
`define TIO_CTRL_RST 32'h0000_0020

`define TIO_STAT_PROT_BIT 0
`define TIO_STAT_RUN_BIT 1
`define TIO_STAT_GATE_BIT 2
`define TIO_STAT_SHOW_BIT 3
`define TIO_STAT_ST_LO 4
`define TIO_STAT_ST_HI 7
`define TIO_STAT_MODE_LO 8
`define TIO_STAT_MODE_HI 9
`define TIO_STAT_NUM_LO 10
`define TIO_STAT_NUM_HI 15

`define TIO_SYNC_W 13

`endif

// ==== common/tester_io_pkg.sv ====
// Types of the tester control port
package tester_io_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RUN = 4'b0010,
        ST_FALL = 4'b0100,
        ST_HOLD = 4'b1000
    } run_state_t;

    typedef enum logic [1:0] {
        SIG_TIMED = 2'h0,
        SIG_PROBE = 2'h1,
        SIG_RISE = 2'h2,
        SIG_WHOLE_RUN_WINDOW = 2'h3
    } test_sig_t;

    typedef enum logic [1:0] {
        MODE_WITHSTAND = 2'h0,
        MODE_INSULATION = 2'h1,
        MODE_BREAKDOWN = 2'h2,
        MODE_PROGRAM = 2'h3
    } test_mode_t;

endpackage

// ==== hw/pin_sync.sv ====
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 13
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ==== hw/tester_external_control_io.sv ====
// External control port logic of the high-voltage tester
`timescale 1ns/1ps
`default_nettype none
`include "tester_io_defs.svh"

// Overview of operation
// [RULE1] Start edge with gate on begins a test with the current conditions
// [RULE2] Safety lock input on releases protection and allows operation
// [RULE3] Safety lock off enters protection, ends any test, refuses start
// [RULE4] Safety lock and stop act regardless of the input gate
// [RULE5] All other inputs are ignored while the input gate is off
// [RULE6] Stop edge ends any test in progress
// [RULE7] Load-execute edge loads conditions chosen by the panel select bits
// [RULE8] Measurement fault output follows measuring system error
// [RULE9] Upper fail output shows an upper-limit failure
// [RULE10] Lower fail output shows a lower-limit failure
// [RULE11] High-voltage-present output on while voltage is or remains applied
// [RULE12] Withstand fail and insulation fail outputs per failed test kind
// [RULE13] Mode outputs show the selected withstand or insulation mode
// [RULE14] Step-done and program-done outputs during program tests
// [RULE15] Arc output on arc detection during withstand tests
// [RULE16] Pass output on pass judgment with the selected timing pattern
// [RULE17] General outputs on while the instrument is in their set state
// [RULE18] Ready, protection and contact fault outputs follow their states
// [RULE19] Separate judgment timing choice for withstand and insulation
// [RULE20] Contact check forces voltage-off judgment timing
// [RULE21] Voltage-off pattern shows at voltage removal, other at test end
// [RULE22] Probe mode: test-active from start until voltage off
// [RULE23] Timed mode: test-active only during the test time
// [RULE24] Rise mode until voltage reached; whole-run mode until test end
// [RULE25] Select bits 7:6 choose test mode, bits 5:0 the memory number
// [RULE26] Controller loads only while no test runs, selects set first
// [RULE27] Stop edge also releases held judgment outputs
// [RULE28] Source wiring: asserted is high; sink wiring inverts levels
// [RULE29] Inputs synchronised; start, stop, load-execute act on rising edge
module tester_external_control_io (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start_pin,
    input wire logic i_safety_lock_pin,
    input wire logic i_stop_pin,
    input wire logic i_external_input_gate,
    input wire logic i_panel_load_execute,
    input wire logic [7:0] i_panel_select_bits,
    input wire logic i_hv_present,
    input wire logic i_whole_run_window_error,
    input wire logic i_arc_detect,
    input wire logic i_contact_error,
    input wire logic i_ready_state,
    input wire logic [1:0] i_gp_state_hit,
    input wire logic i_voltage_reached,
    input wire logic i_test_time_active,
    input wire logic i_voltage_off,
    input wire logic i_test_done,
    input wire logic i_judge_pass,
    input wire logic i_judge_upper,
    input wire logic i_judge_lower,
    input wire logic i_judge_insulation,
    input wire logic i_step_done,
    input wire logic i_program_done,
    input wire logic [`TIO_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_start_req,
    output logic o_stop_req,
    output logic o_load_req,
    output logic [1:0] o_load_mode,
    output logic [5:0] o_load_number,
    output logic o_whole_run_window_fault_out,
    output logic o_upper_fail_out,
    output logic o_lower_fail_out,
    output logic o_hv_present_out,
    output logic o_withstand_fail_out,
    output logic o_withstand_selected_out,
    output logic o_step_done_out,
    output logic o_arc_seen_out,
    output logic o_pass_out,
    output logic o_test_active_out,
    output logic o_ready_out,
    output logic o_protection_out,
    output logic o_contact_fault_out,
    output logic o_insulation_fail_out,
    output logic o_insulation_selected_out,
    output logic o_program_done_out,
    output logic [1:0] o_general_outputs
);

    // ************************************************************
    // Pin synchronisation and polarity
    // ************************************************************

    logic [`TIO_SYNC_W-1:0] pin_s;
    logic [`TIO_SYNC_W-1:0] lvl;
    logic [`TIO_SYNC_W-1:0] prev_q;
    logic [`TIO_SYNC_W-1:0] rise;
    logic sink_q;
    logic [1:0] sync_ok_q;

    pin_sync #(
        .WIDTH(`TIO_SYNC_W)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_panel_select_bits, i_panel_load_execute, i_external_input_gate,
                  i_stop_pin, i_safety_lock_pin, i_start_pin}),
        .o_sync(pin_s)
    );

    // Sink wiring reads an asserted contact as a low level; all off until the flops fill
    assign lvl = sync_ok_q[1] ? pin_s ^ {`TIO_SYNC_W{sink_q}} : '0; // see [RULE28]

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_q <= '0;
            sync_ok_q <= 2'b00;
        end else begin
            prev_q <= lvl;
            sync_ok_q <= {sync_ok_q[0], 1'b1};
        end
    end

    assign rise = lvl & ~prev_q; // see [RULE29]

    logic start_rise;
    logic lock_on;
    logic lock_fall;
    logic stop_rise;
    logic gate_on;
    logic load_rise;
    logic [7:0] sel;

    assign start_rise = rise[0];
    assign lock_on = lvl[1];
    assign lock_fall = prev_q[1] & ~lvl[1];
    assign stop_rise = rise[2];
    assign gate_on = lvl[3];
    assign load_rise = rise[4];
    assign sel = lvl[12:5];

    // ************************************************************
    // Control register and protection
    // ************************************************************

    localparam logic [31:0] CTRL_RST = `TIO_CTRL_RST;
    logic jw_end_q;
    logic ji_end_q;
    tester_io_pkg::test_sig_t sig_q;
    logic cc_en_q;
    logic protect_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            jw_end_q <= CTRL_RST[`TIO_CTRL_JW_BIT];
            ji_end_q <= CTRL_RST[`TIO_CTRL_JI_BIT];
            sig_q <= tester_io_pkg::test_sig_t'(CTRL_RST[`TIO_CTRL_SIG_HI:`TIO_CTRL_SIG_LO]);
            cc_en_q <= CTRL_RST[`TIO_CTRL_CC_BIT];
            sink_q <= CTRL_RST[`TIO_CTRL_SINK_BIT];
        end else if (i_wr && i_addr == `TIO_CTRL_OFS) begin
            jw_end_q <= i_wdata[`TIO_CTRL_JW_BIT]; // see [RULE19]
            ji_end_q <= i_wdata[`TIO_CTRL_JI_BIT]; // see [RULE19]
            sig_q <= tester_io_pkg::test_sig_t'(i_wdata[`TIO_CTRL_SIG_HI:`TIO_CTRL_SIG_LO]);
            cc_en_q <= i_wdata[`TIO_CTRL_CC_BIT];
            sink_q <= i_wdata[`TIO_CTRL_SINK_BIT];
        end
    end

    // Protection holds while the lock input is off, ungated
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            protect_q <= 1'b1;
        end else begin
            protect_q <= ~lock_on; // see [RULE2] see [RULE3] see [RULE4]
        end
    end

    // ************************************************************
    // Test sequence
    // ************************************************************

    tester_io_pkg::run_state_t st_q;
    logic idle_like;
    logic abort;
    logic start_go;
    logic load_go;

    assign idle_like = (st_q == tester_io_pkg::ST_IDLE) || (st_q == tester_io_pkg::ST_HOLD);
    assign abort = stop_rise || ~lock_on; // see [RULE4] see [RULE6]
    // see [RULE1] see [RULE3] see [RULE5]
    assign start_go = start_rise && gate_on && lock_on && !protect_q && idle_like && !abort;
    // see [RULE5] see [RULE26]
    assign load_go = load_rise && gate_on && idle_like && !abort;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= tester_io_pkg::ST_IDLE;
        end else if (abort) begin
            st_q <= tester_io_pkg::ST_IDLE; // see [RULE6]
        end else begin
            case (st_q)
                tester_io_pkg::ST_IDLE, tester_io_pkg::ST_HOLD: begin
                    if (start_go) begin
                        st_q <= tester_io_pkg::ST_RUN; // see [RULE1]
                    end
                end
                tester_io_pkg::ST_RUN: begin
                    if (i_test_done) begin
                        st_q <= tester_io_pkg::ST_FALL;
                    end
                end
                tester_io_pkg::ST_FALL: begin
                    if (i_voltage_off) begin
                        st_q <= tester_io_pkg::ST_HOLD;
                    end
                end
                default: begin
                    st_q <= tester_io_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_start_req <= 1'b0;
            o_stop_req <= 1'b0;
        end else begin
            o_start_req <= start_go;
            o_stop_req <= stop_rise || lock_fall;
        end
    end

    // ************************************************************
    // Panel load and mode outputs
    // ************************************************************

    tester_io_pkg::test_mode_t mode_d;

    always_comb begin
        mode_d = tester_io_pkg::test_mode_t'(o_load_mode);
        if (load_go) begin
            mode_d = tester_io_pkg::test_mode_t'(sel[7:6]); // see [RULE25]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_load_req <= 1'b0;
            o_load_mode <= tester_io_pkg::MODE_WITHSTAND;
            o_load_number <= 6'h00;
            o_withstand_selected_out <= 1'b1;
            o_insulation_selected_out <= 1'b0;
        end else begin
            o_load_req <= load_go; // see [RULE7]
            o_load_mode <= mode_d;
            if (load_go) begin
                o_load_number <= sel[5:0]; // see [RULE25]
            end
            o_withstand_selected_out <= mode_d == tester_io_pkg::MODE_WITHSTAND; // see [RULE13]
            o_insulation_selected_out <= mode_d == tester_io_pkg::MODE_INSULATION; // see [RULE13]
        end
    end

    // ************************************************************
    // Judgment outputs
    // ************************************************************

    // High when the judgment shows at test end rather than at voltage off
    function automatic logic judge_at_end(input logic ir, input logic jw, input logic ji,
                                          input logic cc);
        judge_at_end = !cc && (ir ? ji : jw); // see [RULE20] see [RULE21]
    endfunction

    logic take_res;
    logic show_q;
    logic show_d;
    logic pass_q;
    logic up_q;
    logic lo_q;
    logic ir_q;
    logic pass_d;
    logic up_d;
    logic lo_d;
    logic ir_d;

    assign take_res = (st_q == tester_io_pkg::ST_RUN) && i_test_done && !abort;

    always_comb begin
        pass_d = take_res ? i_judge_pass : pass_q;
        up_d = take_res ? i_judge_upper : up_q;
        lo_d = take_res ? i_judge_lower : lo_q;
        ir_d = take_res ? i_judge_insulation : ir_q;
        show_d = show_q;
        if (abort || start_go) begin
            show_d = 1'b0; // see [RULE27]
        end else if (take_res && judge_at_end(i_judge_insulation, jw_end_q, ji_end_q, cc_en_q)) begin
            show_d = 1'b1; // see [RULE21]
        end else if (st_q == tester_io_pkg::ST_FALL && i_voltage_off) begin
            show_d = 1'b1; // see [RULE21]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            show_q <= 1'b0;
            pass_q <= 1'b0;
            up_q <= 1'b0;
            lo_q <= 1'b0;
            ir_q <= 1'b0;
            o_pass_out <= 1'b0;
            o_upper_fail_out <= 1'b0;
            o_lower_fail_out <= 1'b0;
            o_withstand_fail_out <= 1'b0;
            o_insulation_fail_out <= 1'b0;
        end else begin
            show_q <= show_d;
            pass_q <= pass_d;
            up_q <= up_d;
            lo_q <= lo_d;
            ir_q <= ir_d;
            o_pass_out <= show_d && pass_d; // see [RULE16]
            o_upper_fail_out <= show_d && up_d; // see [RULE9]
            o_lower_fail_out <= show_d && lo_d; // see [RULE10]
            o_withstand_fail_out <= show_d && !pass_d && !ir_d; // see [RULE12]
            o_insulation_fail_out <= show_d && !pass_d && ir_d; // see [RULE12]
        end
    end

    // ************************************************************
    // Test-active output
    // ************************************************************

    logic win_q;
    logic win_d;

    always_comb begin
        win_d = win_q;
        if (abort) begin
            win_d = 1'b0;
        end else if (start_go) begin
            win_d = 1'b1;
        end else begin
            case (sig_q)
                tester_io_pkg::SIG_PROBE: begin
                    if (i_voltage_off) begin
                        win_d = 1'b0; // see [RULE22]
                    end
                end
                tester_io_pkg::SIG_RISE: begin
                    if (i_voltage_reached || i_test_done) begin
                        win_d = 1'b0; // see [RULE24]
                    end
                end
                tester_io_pkg::SIG_WHOLE_RUN_WINDOW: begin
                    if (i_test_done) begin
                        win_d = 1'b0; // see [RULE24]
                    end
                end
                default: begin
                    win_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            win_q <= 1'b0;
            o_test_active_out <= 1'b0;
        end else begin
            win_q <= win_d;
            if (sig_q == tester_io_pkg::SIG_TIMED) begin
                // see [RULE23]
                o_test_active_out <= st_q == tester_io_pkg::ST_RUN && i_test_time_active && !abort;
            end else begin
                o_test_active_out <= win_d;
            end
        end
    end

    // ************************************************************
    // Status outputs from the sequencer
    // ************************************************************

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_whole_run_window_fault_out <= 1'b0;
            o_hv_present_out <= 1'b0;
            o_arc_seen_out <= 1'b0;
            o_contact_fault_out <= 1'b0;
            o_ready_out <= 1'b0;
            o_protection_out <= 1'b1;
            o_general_outputs <= 2'h0;
            o_step_done_out <= 1'b0;
            o_program_done_out <= 1'b0;
        end else begin
            o_whole_run_window_fault_out <= i_whole_run_window_error; // see [RULE8]
            o_hv_present_out <= i_hv_present; // see [RULE11]
            o_arc_seen_out <= i_arc_detect && !i_judge_insulation; // see [RULE15]
            o_contact_fault_out <= i_contact_error; // see [RULE18]
            o_ready_out <= i_ready_state && lock_on; // see [RULE18]
            o_protection_out <= ~lock_on; // see [RULE18] see [RULE3]
            o_general_outputs <= i_gp_state_hit; // see [RULE17]
            o_step_done_out <= i_step_done && o_load_mode == tester_io_pkg::MODE_PROGRAM; // see [RULE14]
            o_program_done_out <= i_program_done && o_load_mode == tester_io_pkg::MODE_PROGRAM; // see [RULE14]
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= 32'h0000_0000;
            if (i_addr == `TIO_CTRL_OFS) begin
                o_rdata[`TIO_CTRL_JW_BIT] <= jw_end_q;
                o_rdata[`TIO_CTRL_JI_BIT] <= ji_end_q;
                o_rdata[`TIO_CTRL_SIG_HI:`TIO_CTRL_SIG_LO] <= sig_q;
                o_rdata[`TIO_CTRL_CC_BIT] <= cc_en_q;
                o_rdata[`TIO_CTRL_SINK_BIT] <= sink_q;
            end else if (i_addr == `TIO_STAT_OFS) begin
                o_rdata[`TIO_STAT_PROT_BIT] <= protect_q;
                o_rdata[`TIO_STAT_RUN_BIT] <= !idle_like;
                o_rdata[`TIO_STAT_GATE_BIT] <= gate_on;
                o_rdata[`TIO_STAT_SHOW_BIT] <= show_q;
                o_rdata[`TIO_STAT_ST_HI:`TIO_STAT_ST_LO] <= st_q;
                o_rdata[`TIO_STAT_MODE_HI:`TIO_STAT_MODE_LO] <= o_load_mode;
                o_rdata[`TIO_STAT_NUM_HI:`TIO_STAT_NUM_LO] <= o_load_number;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************

    a_start_taken: assert property (@(posedge i_clk) disable iff (i_rst) // see [RULE1]
        start_go |=> o_start_req && st_q == tester_io_pkg::ST_RUN)
        else $error("start edge did not begin a test");

    a_gate_blocks: assert property (@(posedge i_clk) disable iff (i_rst) // see [RULE5]
        !gate_on |=> !o_start_req && !o_load_req)
        else $error("gated-off input was acted on");

    a_lock_protect: assert property (@(posedge i_clk) disable iff (i_rst) // see [RULE3]
        !lock_on |=> o_protection_out && st_q == tester_io_pkg::ST_IDLE && !o_start_req)
        else $error("lock off did not enter protection");

    a_stop_release: assert property (@(posedge i_clk) disable iff (i_rst) // see [RULE27]
        stop_rise |=> o_stop_req && !o_pass_out && !o_upper_fail_out && !o_test_active_out)
        else $error("stop did not end test and release judgment");

    a_load_fields: assert property (@(posedge i_clk) disable iff (i_rst) // see [RULE7]
        load_go |=> o_load_req && o_load_number == $past(sel[5:0]) && o_load_mode == $past(sel[7:6]))
        else $error("panel load fields wrong");

    a_hv_follow: assert property (@(posedge i_clk) disable iff (i_rst) // see [RULE11]
        i_hv_present |=> o_hv_present_out)
        else $error("voltage present not shown");

    a_mode_excl: assert property (@(posedge i_clk) disable iff (i_rst) // see [RULE13]
        !(o_withstand_selected_out && o_insulation_selected_out))
        else $error("both mode outputs on");

    a_cc_timing: assert property (@(posedge i_clk) disable iff (i_rst) // see [RULE20]
        cc_en_q && take_res && !show_q |=> !o_pass_out && !o_upper_fail_out && !o_lower_fail_out)
        else $error("contact check showed judgment before voltage off");

    a_end_timing: assert property (@(posedge i_clk) disable iff (i_rst) // see [RULE21]
        take_res && judge_at_end(i_judge_insulation, jw_end_q, ji_end_q, cc_en_q) && i_judge_pass
        |=> o_pass_out)
        else $error("test-end pattern did not show pass");

    a_rise_window: assert property (@(posedge i_clk) disable iff (i_rst) // see [RULE24]
        sig_q == tester_io_pkg::SIG_RISE && win_q && i_voltage_reached && !start_go
        |=> !o_test_active_out)
        else $error("rise window not closed at voltage reached");

endmodule

`default_nettype wire

// ==== bench/plc_model.sv ====
// Behavioural external controller driving the tester control pins
`timescale 1ns/1ps
`default_nettype none

module plc_model (
    input wire logic i_clk,
    input wire logic i_sink,
    output logic o_start_pin,
    output logic o_safety_lock_pin,
    output logic o_stop_pin,
    output logic o_external_input_gate,
    output logic o_panel_load_execute,
    output logic [7:0] o_panel_select_bits
);
    logic start = 0, lock = 0, stop = 0, gate = 0, load = 0;
    logic [7:0] sel = 8'h00;

    // Sink wiring shows an asserted contact as a low level
    assign o_start_pin = start ^ i_sink;
    assign o_safety_lock_pin = lock ^ i_sink;
    assign o_stop_pin = stop ^ i_sink;
    assign o_external_input_gate = gate ^ i_sink;
    assign o_panel_load_execute = load ^ i_sink;
    assign o_panel_select_bits = sel ^ {8{i_sink}};

    // One edge event, low long enough afterwards to part edges
    task hit(input int k);
        @(posedge i_clk);
        case (k)
            0: start <= 1;
            1: stop <= 1;
            default: load <= 1;
        endcase
        repeat (4) @(posedge i_clk);
        {start, stop, load} <= 3'b000;
        repeat (4) @(posedge i_clk);
    endtask

    // Select bits settle before the load edge; called only with no test running
    task load_panel(input logic [7:0] s);
        @(posedge i_clk);
        sel <= s;
        repeat (3) @(posedge i_clk);
        hit(2);
    endtask
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking testbench of the tester control port
`timescale 1ns/1ps
`default_nettype none
`include "tester_io_defs.svh"

module tb_top;
    logic i_clk = 0, i_rst = 1, sink = 1, i_wr = 0, i_rd = 0;
    logic [`TIO_ADDR_W-1:0] i_addr = 0;
    logic [31:0] i_wdata = 0, d;
    logic i_hv_present = 0, i_whole_run_window_error = 0, i_arc_detect = 0, i_contact_error = 0;
    logic i_ready_state = 0, i_voltage_reached = 0, i_test_time_active = 0, i_voltage_off = 0;
    logic i_test_done = 0, i_judge_pass = 0, i_judge_upper = 0, i_judge_lower = 0;
    logic i_judge_insulation = 0, i_step_done = 0, i_program_done = 0;
    logic [1:0] i_gp_state_hit = 0, o_load_mode, o_general_outputs;
    logic [31:0] o_rdata;
    logic [5:0] o_load_number;
    logic o_start_req, o_stop_req, o_load_req, o_whole_run_window_fault_out, o_upper_fail_out;
    logic o_lower_fail_out, o_hv_present_out, o_withstand_fail_out, o_withstand_selected_out;
    logic o_step_done_out, o_arc_seen_out, o_pass_out, o_test_active_out, o_ready_out;
    logic o_protection_out, o_contact_fault_out, o_insulation_fail_out;
    logic o_insulation_selected_out, o_program_done_out;
    wire logic i_start_pin, i_safety_lock_pin, i_stop_pin, i_external_input_gate;
    wire logic i_panel_load_execute;
    wire logic [7:0] i_panel_select_bits;
    int err_count = 0, cmp_count = 0, n_start = 0, n_stop = 0, n_load = 0, s;

    tester_external_control_io dut (.*);
    plc_model plc (.i_clk(i_clk), .i_sink(sink), .o_start_pin(i_start_pin),
        .o_safety_lock_pin(i_safety_lock_pin), .o_stop_pin(i_stop_pin),
        .o_external_input_gate(i_external_input_gate),
        .o_panel_load_execute(i_panel_load_execute), .o_panel_select_bits(i_panel_select_bits));

    always #20 i_clk = ~i_clk;

    // Request pulses last one cycle, so they are counted as they pass
    always @(posedge i_clk) begin
        if (o_start_req === 1'b1) n_start++;
        if (o_stop_req === 1'b1) n_stop++;
        if (o_load_req === 1'b1) n_load++;
    end

    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_rd <= 1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 0;
        #1 v = o_rdata;
    endtask

    // One withstand test ending in pass or upper fail; late means voltage-off timing
    task judge(input logic [31:0] ctrl, input logic late, input logic p);
        wr(`TIO_CTRL_OFS, ctrl);
        s = n_start;
        plc.hit(0);
        chk("start_req", n_start - s, 1);
        chk("test_active", o_test_active_out, ctrl[3:2] != 0);
        i_voltage_reached <= 1;
        @(posedge i_clk);
        i_voltage_reached <= 0;
        i_test_done <= 1;
        {i_judge_pass, i_judge_upper} <= p ? 2'b10 : 2'b01;
        @(posedge i_clk);
        i_test_done <= 0;
        repeat (3) @(posedge i_clk);
        #1 chk("judge_early", {o_pass_out, o_upper_fail_out, o_test_active_out},
            late ? 0 : {p, !p, 1'b0});
        @(posedge i_clk);
        i_voltage_off <= 1;
        @(posedge i_clk);
        i_voltage_off <= 0;
        repeat (2) @(posedge i_clk);
        #1 chk("judge", {o_pass_out, o_upper_fail_out}, {p, !p});
        chk("withstand_fail", o_withstand_fail_out, !p);
        s = n_stop;
        plc.hit(1);
        chk("stop_req", n_stop - s, 1);
        #1 chk("judge_released", {o_pass_out, o_upper_fail_out}, 0);
        $display("test judge %h done", ctrl);
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        summarize;
    end

    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 0;
        rd(`TIO_CTRL_OFS, d);
        chk("ctrl_reset", d, `TIO_CTRL_RST);
        rd(8'h40, d);
        chk("unmapped", d, 0);
        chk("protect_reset", o_protection_out, 1);
        @(posedge i_clk);
        plc.lock <= 1;
        repeat (5) @(posedge i_clk);
        #1 chk("protect_off", o_protection_out, 0);
        s = n_start;
        plc.hit(0);
        chk("gated_start", n_start - s, 0);
        s = n_stop;
        plc.hit(1);
        chk("ungated_stop", n_stop - s, 1);
        $display("test reset done");
        @(posedge i_clk);
        plc.gate <= 1;
        judge(32'h20, 1, 1);
        judge(32'h29, 0, 0);
        judge(32'h3d, 1, 0);
        s = n_load;
        plc.load_panel(8'h45);
        chk("load_req", n_load - s, 1);
        chk("load_sel", {o_load_mode, o_load_number}, 8'h45);
        chk("ir_selected", {o_insulation_selected_out, o_withstand_selected_out}, 2'b10);
        @(posedge i_clk);
        {i_whole_run_window_error, i_hv_present, i_arc_detect, i_gp_state_hit} <= 5'b11110;
        {i_ready_state, i_contact_error, i_test_time_active, i_step_done, i_program_done} <= 5'h1f;
        repeat (2) @(posedge i_clk);
        #1 chk("levels", {o_whole_run_window_fault_out, o_hv_present_out, o_arc_seen_out, o_general_outputs,
            o_ready_out, o_contact_fault_out, o_step_done_out, o_program_done_out},
            9'h1ec);
        $display("test levels done");
        @(posedge i_clk);
        plc.lock <= 0;
        repeat (5) @(posedge i_clk);
        #1 chk("protect_on", o_protection_out, 1);
        s = n_start;
        plc.hit(0);
        chk("locked_start", n_start - s, 0);
        $display("test lock done");
        summarize;
    end
endmodule

`default_nettype wire
